// file: hdl/src_map.vh
`ifndef SRC_MAP_VH
`define SRC_MAP_VH
`define SRC_ADDR_CAUSE 4'h0
`define SRC_ADDR_STATUS 4'h4
`define SRC_ADDR_MASK 4'h8
`define SRC_ADDR_CTRL 4'hC
`define SRC_BIT_POR 0
`define SRC_BIT_PIN 1
`define SRC_BIT_BOD 2
`define SRC_BIT_WDT 3
`define SRC_BIT_TST 4
`define SRC_CAUSE_RST 5'h01
`define SRC_MASK_RST 5'h00
`define SRC_CTRL_RST 2'h0
`define SRC_PIN_MIN_NS 1500
`define SRC_CLK_NS 10
`define SRC_PIN_MIN_CYC ((`SRC_PIN_MIN_NS + `SRC_CLK_NS - 1) / `SRC_CLK_NS)
`define SRC_VECTOR 16'h0000
`define SRC_STRETCH_0 20'h00004
`define SRC_STRETCH_1 20'h00400
`define SRC_STRETCH_2 20'h01000
`define SRC_STRETCH_3 20'h10000
`endif

// file: hdl/src_reset_ctrl.v
// Notes on behaviour
// - Reset loads I/O defaults, then fetch vector
// - Ports reset asynchronously when any source but the watchdog is active
// - Delay counter stretches reset after sources release
// - Stretch length chosen by clock-select fuses
// - Exactly five reset request inputs accepted
// - Power-on holds reset while supply low
// - Pin reset needs low beyond minimum width
// - Watchdog reset only when enabled and expired
// - Brown-out reset only when enabled and low
// - Test-port register one holds reset
// - Watchdog gives one-cycle pulse, delay follows
// - Cause flags set; cleared by power-on or zero-write
// - Power-on flag cleared only by zero-write
//
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`include "src_map.vh"
module src_reset_ctrl
(
	input wire clk,
	input wire srst,
	input wire supply_below_por,
	input wire reset_pin_n,
	input wire wdt_enable,
	input wire wdt_expired,
	input wire bod_enable,
	input wire supply_below_bod,
	input wire test_reset_reg,
	input wire [3:0] clock_select_fuses,
	input wire [31:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	input wire wb_we_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output reg wb_err_o,
	output wire port_reset,
	output reg internal_reset,
	output reg [15:0] fetch_addr,
	output reg fetch_start,
	output reg irq
);
	reg [4:0] reset_cause_register;
	reg [4:0] status;
	reg [4:0] mask;
	reg [1:0] ctrl;
	reg [7:0] pin_low_cnt;
	reg pin_req;
	reg wdt_pulse;
	reg wdt_exp_d;
	reg [19:0] stretch_cnt;
	reg [19:0] next_stretch_load;
	reg por_req;
	reg bod_req;
	reg tst_req;
	wire any_req;
	wire acc;
	wire wr;
	wire [4:0] ev;
	wire [4:0] wdat;

	// Stretch length per fuse setting
	always @*
	begin
		case (clock_select_fuses[1:0])
			2'h0: next_stretch_load = `SRC_STRETCH_0;
			2'h1: next_stretch_load = `SRC_STRETCH_1;
			2'h2: next_stretch_load = `SRC_STRETCH_2;
			default: next_stretch_load = `SRC_STRETCH_3;
		endcase
	end

	always @(posedge clk)
	begin
		por_req <= supply_below_por;
		bod_req <= bod_enable & supply_below_bod;
		tst_req <= test_reset_reg;
		wdt_exp_d <= wdt_expired;
	end

	// Pin low-time qualifier
	always @(posedge clk)
	begin
		if (reset_pin_n)
		begin
			pin_low_cnt <= 8'h00;
			pin_req <= 1'b0;
		end
		else if (pin_low_cnt >= `SRC_PIN_MIN_CYC)
			pin_req <= 1'b1;
		else
			pin_low_cnt <= pin_low_cnt + 8'h01;
	end

	always @(posedge clk)
	begin
		if (srst)
			wdt_pulse <= 1'b0;
		else
			wdt_pulse <= wdt_enable & wdt_expired & ~wdt_exp_d;
	end

	assign any_req = por_req | pin_req | wdt_pulse | bod_req | tst_req;
	// Asynchronous port reset from raw sources; watchdog only via registered wdt_pulse
	assign port_reset = supply_below_por | ~reset_pin_n | (bod_enable & supply_below_bod)
		| test_reset_reg | wdt_pulse | internal_reset;

	// Stretch counter
	always @(posedge clk)
	begin
		if (srst)
		begin
			stretch_cnt <= 20'h00000;
			internal_reset <= 1'b1;
			fetch_start <= 1'b0;
			fetch_addr <= `SRC_VECTOR;
		end
		else
		begin
			fetch_start <= 1'b0;
			if (any_req)
			begin
				stretch_cnt <= next_stretch_load;
				internal_reset <= 1'b1;
			end
			else if (stretch_cnt != 20'h00000)
				stretch_cnt <= stretch_cnt - 20'h00001;
			else if (internal_reset)
			begin
				internal_reset <= 1'b0;
				fetch_start <= 1'b1;
				fetch_addr <= `SRC_VECTOR;
			end
		end
	end

	assign ev = {tst_req, wdt_pulse, bod_req, pin_req, por_req};
	assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign wr = acc & wb_we_i & wb_sel_i[0];
	assign wdat = wb_dat_i[4:0];

	// Bus slave and registers
	always @(posedge clk)
	begin
		if (srst)
		begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			status <= 5'h00;
			mask <= `SRC_MASK_RST;
			ctrl <= `SRC_CTRL_RST;
			irq <= 1'b0;
		end
		else
		begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			if (acc)
			begin
				case (wb_adr_i[3:0])
					`SRC_ADDR_CAUSE: wb_dat_o <= {27'h0, reset_cause_register};
					`SRC_ADDR_STATUS: wb_dat_o <= {27'h0, status};
					`SRC_ADDR_MASK: wb_dat_o <= {27'h0, mask};
					`SRC_ADDR_CTRL: wb_dat_o <= {29'h0, internal_reset, port_reset};
					default: wb_dat_o <= 32'h00000000;
				endcase
				if (wb_adr_i[31:4] == 28'h0 && wb_adr_i[1:0] == 2'h0)
					wb_ack_o <= 1'b1;
				else
					wb_err_o <= 1'b1;
			end
			if (wr && wb_adr_i == {28'h0, `SRC_ADDR_MASK})
				mask <= wdat;
			if (wr && wb_adr_i == {28'h0, `SRC_ADDR_CTRL})
				ctrl <= wdat[1:0];
			if (wr && wb_adr_i == {28'h0, `SRC_ADDR_STATUS})
				status <= (status & ~wdat) | ev;
			else
				status <= status | ev;
			irq <= |(status & mask);
		end
	end

	// Cause flags survive srst; set wins over zero-write
	always @(posedge clk)
	begin
		if (wr && wb_adr_i == {28'h0, `SRC_ADDR_CAUSE})
			reset_cause_register <= (reset_cause_register & wdat) | ev;
		else if (por_req)
			reset_cause_register <= `SRC_CAUSE_RST;
		else
			reset_cause_register <= reset_cause_register | ev;
	end
endmodule

// file: verification/src_pin_drv.sv
`timescale 1ns/10ps
module src_pin_drv (input wire clk, input wire go, input wire [7:0] len, output wire reset_pin_n);
	reg [7:0] cnt = 8'h00;
	assign reset_pin_n = cnt == 8'h00;
	always @(posedge clk) cnt <= go ? len : cnt - {7'h00, !reset_pin_n};
endmodule

// file: verification/src_reset_ctrl_chk.sv
`timescale 1ns/10ps
module src_reset_ctrl_chk (input wire clk, srst, supply_below_por, wdt_enable, wdt_expired,
	bod_enable, supply_below_bod, test_reset_reg, port_reset, internal_reset, fetch_start);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	property p_por; supply_below_por |-> ##2 internal_reset; endproperty
	a_por: assert property (p_por) else $error("por");
	property p_tst; test_reset_reg |-> ##2 internal_reset; endproperty
	a_tst: assert property (p_tst) else $error("tst");
	property p_bod; bod_enable && supply_below_bod |-> ##2 internal_reset; endproperty
	a_bod: assert property (p_bod) else $error("bod");
	property p_wdt; wdt_enable && $rose(wdt_expired) |-> ##[1:3] internal_reset; endproperty
	a_wdt: assert property (p_wdt) else $error("wdt");
	property p_prt; supply_below_por || test_reset_reg |-> port_reset; endproperty
	a_prt: assert property (p_prt) else $error("prt");
	property p_fs; $fell(internal_reset) |-> fetch_start; endproperty
	a_fs: assert property (p_fs) else $error("fs");
	property p_hold; $fell(supply_below_por) |-> ##4 internal_reset; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_rel; $fell(internal_reset) |-> !$past(test_reset_reg, 3); endproperty
	a_rel: assert property (p_rel) else $error("rel");
endmodule
bind src_reset_ctrl src_reset_ctrl_chk i_chk (.*);

// file: verification/testbench.sv
`timescale 1ns/10ps
module testbench;
	reg clk, srst, supply_below_por, wdt_enable, wdt_expired, bod_enable, supply_below_bod;
	reg test_reset_reg, wb_we_i, wb_cyc_i, go, qe;
	reg [7:0] len;
	reg [3:0] fuses;
	reg [31:0] wb_adr_i, wb_dat_i, q;
	wire [31:0] wb_dat_o;
	wire [15:0] fetch_addr;
	wire wb_ack_o, wb_err_o, port_reset, internal_reset, fetch_start, irq, reset_pin_n;
	wire wb_stb_i = wb_cyc_i;
	integer err_count = 0, checked = 0, n, i;
	src_pin_drv i_pin (.*);
	src_reset_ctrl i_dut (.*, .wb_sel_i(4'hF), .clock_select_fuses(fuses));
	initial forever #5 clk = ~clk;
	task chk(input [31:0] s, input [31:0] x);
	begin
		checked = checked + 1;
		err_count = err_count + (s !== x);
		if (s !== x) $display("mismatch %0t %h %h", $time, s, x);
	end
	endtask
	task bus(input w, input [31:0] a, input [31:0] d);
	begin
		@(posedge clk);
		{wb_cyc_i, wb_we_i, wb_adr_i, wb_dat_i} <= {1'h1, w, a, d};
		for (n = 0; n < 50 && (wb_ack_o | wb_err_o) !== 1'h1; n = n + 1) @(posedge clk);
		if (n == 50) err_count = err_count + 1;
		{q, qe} = {wb_dat_o, wb_err_o};
		wb_cyc_i <= 1'h0;
	end
	endtask
	task stop_test(input integer x);
	begin
		err_count = err_count + x;
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	end
	endtask
	initial #100000 stop_test(1);
	initial
	begin
		{wb_cyc_i, wb_we_i, wb_adr_i, wb_dat_i, go, len, clk, srst, supply_below_por} = 78'h3;
		{wdt_enable, wdt_expired, bod_enable, supply_below_bod, test_reset_reg} = 5'h00;
		fuses = 4'h0;
		repeat (4) @(posedge clk);
		{srst, supply_below_por} <= 2'h0;
		for (i = 0; i < 6; i = i + 1)
		begin
			repeat (9) @(posedge clk);
			bus(1'h0, 32'h0, 32'h0);
			chk(q, 32'h1 | 32'h1E & (32'h1 << i) - 32'h1);
			$display("source step %0d done", i);
			{go, len, bod_enable, wdt_enable, test_reset_reg} <=
				{i < 2, i ? 8'hC8 : 8'h32, i == 2, i == 3, i == 4};
			{supply_below_bod, wdt_expired, supply_below_por} <=
				{i == 0 || i == 2, i == 0 || i == 3, i == 5};
			@(posedge clk);
			go <= 1'h0;
			repeat (230) @(posedge clk);
			{supply_below_por, bod_enable, supply_below_bod} <= 3'h0;
			{wdt_enable, wdt_expired, test_reset_reg} <= 3'h0;
		end
		repeat (9) @(posedge clk);
		bus(1'h1, 32'h8, 32'h1E);
		bus(1'h0, 32'h4, 32'h0);
		chk(q & 32'h1E, 32'h1E);
		chk(irq, 1'h1);
		bus(1'h1, 32'h4, 32'h1E);
		bus(1'h0, 32'h0, 32'h0);
		chk(q, 32'h1);
		chk(irq, 1'h0);
		bus(1'h1, 32'h0, 32'h0);
		bus(1'h0, 32'h0, 32'h0);
		chk(q, 32'h0);
		bus(1'h0, 32'h10, 32'h0);
		chk(qe, 1'h1);
		$display("register step done");
		fuses <= 4'h1;
		test_reset_reg <= 1'h1;
		repeat (5) @(posedge clk);
		test_reset_reg <= 1'h0;
		repeat (600) @(posedge clk);
		chk(internal_reset, 1'h1);
		repeat (500) @(posedge clk);
		chk(internal_reset, 1'h0);
		chk(fetch_addr, 32'h0);
		$display("stretch step done");
		stop_test(0);
	end
endmodule
